// ===== core/port_pin_logic.sv
// Module: pin-level logic of the three general-purpose ports
// Operation
// - First port has four pins, each a separately addressable bit.
// - Bit 2 of first port is output only, high-current LED sink.
// - First port bits 0, 1, 3 bidirectional with independent pull-ups.
// - Eight-pin input port, pull-ups enabled together by one select bit.
// - Alternate function on an input-port pin forces its pull-up off.
// - Third port has eight bidirectional pins with individual pull-ups.
// - Either reset tri-states every pin; only the reset pin acts without a clock, core reset waits for an edge.
// - Low level on external reset pin resets without clock; hold long enough.
// - First port data register uses low four bits, upper four unused.
`timescale 1ns/100ps
module port_pin_logic
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ext_reset_n,
    input wire port_pkg::core_write_type core_write,
    input wire logic [2:0] first_port_in,
    input wire logic [7:0] input_port_in,
    input wire logic [7:0] third_port_in,
    output logic [2:0] first_port_out,
    output logic [2:0] first_port_oe_n,
    output logic [2:0] first_port_pullup,
    output logic led_sink_output_pin,
    output logic led_sink_oe_n,
    output logic led_high_current,
    output logic [7:0] input_port_pullup,
    output logic [7:0] third_port_out,
    output logic [7:0] third_port_oe_n,
    output logic [7:0] third_port_pullup,
    output logic [2:0] first_port_read,
    output logic [7:0] input_port_read,
    output logic [7:0] third_port_read,
    output logic [3:0] first_data_read,
    output logic [3:0] first_ctrl_read
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Pull-up only when the pin is an input and its data bit is set
    function automatic logic [7:0] pullup_of(input logic [7:0] dir, input logic [7:0] data);
        pullup_of = ~dir & data;
    endfunction

    // Bits 3, 1, 0 of a first-port nibble packed into three pins
    function automatic logic [2:0] bidir_bits(input logic [3:0] nib);
        bidir_bits = {nib[3], nib[1], nib[0]};
    endfunction

    // ------------------------------------------------------------
    // Configuration and pin driver state
    // ------------------------------------------------------------
    logic [3:0] first_data;
    logic [3:0] first_ctrl;
    logic input_pullup_sel;
    logic [7:0] input_alt;
    logic [7:0] third_data;
    logic [7:0] third_dir;
    logic [3:0] next_first_data;
    logic [3:0] next_first_ctrl;
    logic next_input_pullup_sel;
    logic [7:0] next_input_alt;
    logic [7:0] next_third_data;
    logic [7:0] next_third_dir;
    logic [2:0] next_first_port_out;
    logic [2:0] next_first_port_oe_n;
    logic [2:0] next_first_port_pullup;
    logic next_led_sink_output_pin;
    logic next_led_sink_oe_n;
    logic next_led_high_current;
    logic [7:0] next_input_port_pullup;
    logic [7:0] next_third_port_out;
    logic [7:0] next_third_port_oe_n;
    logic [7:0] next_third_port_pullup;
    logic [7:0] first_dir8;
    logic [7:0] first_pull8;

    // Register writes, then pin drivers from the current register values
    always_comb
    begin
        next_first_data = first_data;
        next_first_ctrl = first_ctrl;
        next_input_pullup_sel = input_pullup_sel;
        next_input_alt = input_alt;
        next_third_data = third_data;
        next_third_dir = third_dir;
        if (core_write.first_data_we)
        begin
            next_first_data = core_write.wdata[3:0];
        end
        if (core_write.first_ctrl_we)
        begin
            next_first_ctrl = core_write.wdata[3:0];
        end
        if (core_write.input_cfg_we)
        begin
            next_input_pullup_sel = core_write.wdata[0];
        end
        if (core_write.input_alt_we)
        begin
            next_input_alt = core_write.wdata;
        end
        if (core_write.third_data_we)
        begin
            next_third_data = core_write.wdata;
        end
        if (core_write.third_dir_we)
        begin
            next_third_dir = core_write.wdata;
        end
        first_dir8 = {4'h0, first_ctrl[port_pkg::CTRL_DIR3_BIT], 1'b0,
                      first_ctrl[port_pkg::CTRL_DIR1_BIT], first_ctrl[port_pkg::CTRL_DIR0_BIT]};
        // Drive low-active enables: a set direction bit drives the pin
        next_first_port_out = bidir_bits(first_data);
        next_first_port_oe_n = ~bidir_bits(first_dir8[3:0]);
        // Function results cannot be part-selected directly, so widen through a temporary
        first_pull8 = pullup_of(first_dir8, {4'h0, first_data});
        next_first_port_pullup = bidir_bits(first_pull8[3:0]);
        next_led_sink_output_pin = first_data[port_pkg::LED_BIT];
        next_led_sink_oe_n = 1'b0;
        next_led_high_current = first_ctrl[port_pkg::CTRL_HIGH_CURRENT_BIT];
        next_input_port_pullup = {8{input_pullup_sel}} & ~input_alt;
        next_third_port_out = third_data;
        next_third_port_oe_n = ~third_dir;
        next_third_port_pullup = pullup_of(third_dir, third_data);
    end

    // Async preset on the reset pin: pins float even with no clock running
    always_ff @(posedge clk or negedge ext_reset_n)
    begin
        if (!ext_reset_n)
        begin
            first_data <= port_pkg::FIRST_DATA_RESET;
            first_ctrl <= port_pkg::FIRST_CTRL_RESET;
            input_pullup_sel <= 1'b0;
            input_alt <= port_pkg::BYTE_RESET;
            third_data <= port_pkg::BYTE_RESET;
            third_dir <= port_pkg::BYTE_RESET;
            first_port_out <= 3'h0;
            first_port_oe_n <= port_pkg::BIDIR_A_RELEASED;
            first_port_pullup <= 3'h0;
            led_sink_output_pin <= 1'b0;
            led_sink_oe_n <= 1'b1;
            led_high_current <= 1'b0;
            input_port_pullup <= port_pkg::BYTE_RESET;
            third_port_out <= port_pkg::BYTE_RESET;
            third_port_oe_n <= port_pkg::BYTE_RELEASED;
            third_port_pullup <= port_pkg::BYTE_RESET;
        end
        else if (reset)
        begin
            first_data <= port_pkg::FIRST_DATA_RESET;
            first_ctrl <= port_pkg::FIRST_CTRL_RESET;
            input_pullup_sel <= 1'b0;
            input_alt <= port_pkg::BYTE_RESET;
            third_data <= port_pkg::BYTE_RESET;
            third_dir <= port_pkg::BYTE_RESET;
            first_port_out <= 3'h0;
            first_port_oe_n <= port_pkg::BIDIR_A_RELEASED;
            first_port_pullup <= 3'h0;
            led_sink_output_pin <= 1'b0;
            led_sink_oe_n <= 1'b1;
            led_high_current <= 1'b0;
            input_port_pullup <= port_pkg::BYTE_RESET;
            third_port_out <= port_pkg::BYTE_RESET;
            third_port_oe_n <= port_pkg::BYTE_RELEASED;
            third_port_pullup <= port_pkg::BYTE_RESET;
        end
        else
        begin
            first_data <= next_first_data;
            first_ctrl <= next_first_ctrl;
            input_pullup_sel <= next_input_pullup_sel;
            input_alt <= next_input_alt;
            third_data <= next_third_data;
            third_dir <= next_third_dir;
            first_port_out <= next_first_port_out;
            first_port_oe_n <= next_first_port_oe_n;
            first_port_pullup <= next_first_port_pullup;
            led_sink_output_pin <= next_led_sink_output_pin;
            led_sink_oe_n <= next_led_sink_oe_n;
            led_high_current <= next_led_high_current;
            input_port_pullup <= next_input_port_pullup;
            third_port_out <= next_third_port_out;
            third_port_oe_n <= next_third_port_oe_n;
            third_port_pullup <= next_third_port_pullup;
        end
    end

    // ------------------------------------------------------------
    // Pin input synchronisers and read-back
    // ------------------------------------------------------------
    logic [18:0] pin_meta;
    logic [18:0] pin_sync;
    logic [18:0] next_pin_meta;
    logic [18:0] next_pin_sync;

    // Two flops per pin; the led sink pin has no input path
    always_comb
    begin
        next_pin_meta = {first_port_in, input_port_in, third_port_in};
        next_pin_sync = pin_meta;
    end

    always_ff @(posedge clk)
    begin
        pin_meta <= next_pin_meta;
        pin_sync <= next_pin_sync;
    end

    assign first_port_read = pin_sync[18:16];
    assign input_port_read = pin_sync[15:8];
    assign third_port_read = pin_sync[7:0];
    assign first_data_read = first_data;
    assign first_ctrl_read = first_ctrl;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_first_write;
        @(posedge clk) disable iff (reset || !ext_reset_n)
        core_write.first_data_we ##1 !reset && ext_reset_n |=> first_port_out == bidir_bits($past(first_data));
    endproperty
    a_first_write: assert property (p_first_write) else $error("First port pins miss written data");

    property p_led_driven;
        @(posedge clk) disable iff (reset || !ext_reset_n)
        $past(ext_reset_n) && !$past(reset) |-> !led_sink_oe_n && led_sink_output_pin == $past(first_data[2]);
    endproperty
    a_led_driven: assert property (p_led_driven) else $error("LED sink pin not driven with its bit");

    property p_first_pullup;
        @(posedge clk) disable iff (reset || !ext_reset_n)
        $past(ext_reset_n) && !$past(reset) |->
            first_port_pullup == bidir_bits(~$past(first_ctrl) & $past(first_data));
    endproperty
    a_first_pullup: assert property (p_first_pullup) else $error("First port pull-up mismatch");

    property p_input_pullup;
        @(posedge clk) disable iff (reset || !ext_reset_n)
        core_write.input_cfg_we && !core_write.input_alt_we && core_write.wdata[0] && input_alt == 8'h00
            ##1 !reset ##1 !reset |-> input_port_pullup == 8'hFF;
    endproperty
    a_input_pullup: assert property (p_input_pullup) else $error("Common pull-up select not applied");

    property p_alt_kills_pullup;
        @(posedge clk) disable iff (reset || !ext_reset_n)
        $past(ext_reset_n) && !$past(reset) |-> (input_port_pullup & $past(input_alt)) == 8'h00;
    endproperty
    a_alt_kills_pullup: assert property (p_alt_kills_pullup) else $error("Pull-up left on alternate pin");

    property p_third_port;
        @(posedge clk) disable iff (reset || !ext_reset_n)
        $past(ext_reset_n) && !$past(reset) |->
            third_port_oe_n == ~$past(third_dir) && third_port_pullup == (~$past(third_dir) & $past(third_data));
    endproperty
    a_third_port: assert property (p_third_port) else $error("Third port drive or pull-up mismatch");

    property p_reset_floats;
        @(posedge clk) disable iff (1'b0)
        !ext_reset_n || $past(reset) |-> first_port_oe_n == 3'h7 && led_sink_oe_n && third_port_oe_n == 8'hFF;
    endproperty
    a_reset_floats: assert property (p_reset_floats) else $error("Pins driven during reset");

    property p_ext_reset;
        @(posedge clk) disable iff (1'b0)
        !ext_reset_n |-> first_data == 4'h0 && third_port_pullup == 8'h00 && input_port_pullup == 8'h00;
    endproperty
    a_ext_reset: assert property (p_ext_reset) else $error("Reset pin did not reset state");

    property p_upper_unused;
        @(posedge clk) disable iff (reset || !ext_reset_n)
        core_write.first_data_we |=> first_data == $past(core_write.wdata[3:0]);
    endproperty
    a_upper_unused: assert property (p_upper_unused) else $error("First data nibble not stored");

    property p_dir_select;
        @(posedge clk) disable iff (reset || !ext_reset_n)
        core_write.third_dir_we && core_write.wdata == 8'hFF ##1 ext_reset_n && !reset ##1 !reset |->
            third_port_oe_n == 8'h00 && third_port_pullup == 8'h00;
    endproperty
    a_dir_select: assert property (p_dir_select) else $error("Output pins keep pull-ups");

endmodule

// ===== core/port_pkg.sv
// Package: shared constants and carrier types for the port pin logic
package port_pkg;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int FIRST_PORT_WIDTH = 4;
    localparam int BIDIR_A_WIDTH = 3;
    localparam int PORT8_WIDTH = 8;
    localparam logic [3:0] FIRST_DATA_RESET = 4'h0;
    localparam logic [3:0] FIRST_CTRL_RESET = 4'h0;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [2:0] BIDIR_A_RELEASED = 3'h7;
    localparam logic [7:0] BYTE_RELEASED = 8'hFF;

    // ------------------------------------------------------------
    // Field positions of the first port control nibble and LED data bit
    // ------------------------------------------------------------
    localparam int CTRL_DIR0_BIT = 0;
    localparam int CTRL_DIR1_BIT = 1;
    localparam int CTRL_HIGH_CURRENT_BIT = 2;
    localparam int CTRL_DIR3_BIT = 3;
    localparam int LED_BIT = 2;

    // ------------------------------------------------------------
    // Reset pin timing: shortest pulse that must register
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int RESET_PULSE_MIN_NS = 50;
    localparam int RESET_PULSE_MIN_CYCLES =
        ((RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
        (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Core-side write request carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic first_data_we;
        logic first_ctrl_we;
        logic input_cfg_we;
        logic input_alt_we;
        logic third_data_we;
        logic third_dir_we;
        logic [7:0] wdata;
    } core_write_type;

endpackage

// ===== dv/pin_partner.sv
// External circuitry at one group of port pins
`timescale 1ns/100ps
module pin_partner
#(
    parameter int W = 8
)
(
    input wire logic clk,
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe_n,
    input wire logic [W-1:0] pin_pullup,
    input wire logic [W-1:0] ext_en,
    input wire logic [W-1:0] ext_val,
    output logic [W-1:0] pin_level
);
    logic float_q = 1'b0;
    // Floating line flips each cycle, so a stale value never looks driven
    always_ff @(posedge clk)
    begin
        float_q <= ~float_q;
    end
    // Device drive first, then outside driver, then pull-up
    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            if (!pin_oe_n[i])
                pin_level[i] = pin_out[i];
            else if (ext_en[i])
                pin_level[i] = ext_val[i];
            else if (pin_pullup[i])
                pin_level[i] = 1'b1;
            else
                pin_level[i] = float_q;
        end
    end
endmodule

// ===== dv/testbench.sv
// Self-checking bench for the port pin logic
`timescale 1ns/100ps
module testbench;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ext_reset_n = 1'b1;
    port_pkg::core_write_type cw = '0;
    logic [2:0] fp_in, fp_out, fp_oe_n, fp_pu, fp_rd, fp_en = '0, fp_val = '0;
    logic [7:0] ip_in, ip_pu, ip_rd, ip_en = '0, ip_val = '0;
    logic [7:0] tp_in, tp_out, tp_oe_n, tp_pu, tp_rd, tp_en = '0, tp_val = '0;
    logic led, led_oe_n, led_hc;
    logic [3:0] fd_rd, fc_rd;
    int failures = 0;
    int n_checks = 0;
    localparam logic [5:0] FD = 6'h20, FC = 6'h10, IC = 6'h08, IA = 6'h04, TD = 6'h02, TR = 6'h01;

    port_pin_logic port_pin_logic_inst (.clk(clk), .reset(reset), .ext_reset_n(ext_reset_n),
        .core_write(cw), .first_port_in(fp_in), .input_port_in(ip_in), .third_port_in(tp_in),
        .first_port_out(fp_out), .first_port_oe_n(fp_oe_n), .first_port_pullup(fp_pu),
        .led_sink_output_pin(led), .led_sink_oe_n(led_oe_n), .led_high_current(led_hc),
        .input_port_pullup(ip_pu), .third_port_out(tp_out), .third_port_oe_n(tp_oe_n),
        .third_port_pullup(tp_pu), .first_port_read(fp_rd), .input_port_read(ip_rd),
        .third_port_read(tp_rd), .first_data_read(fd_rd), .first_ctrl_read(fc_rd));
    pin_partner #(.W(3)) first_side (.clk(clk), .pin_out(fp_out), .pin_oe_n(fp_oe_n),
        .pin_pullup(fp_pu), .ext_en(fp_en), .ext_val(fp_val), .pin_level(fp_in));
    pin_partner #(.W(8)) input_side (.clk(clk), .pin_out(8'h00), .pin_oe_n(8'hFF),
        .pin_pullup(ip_pu), .ext_en(ip_en), .ext_val(ip_val), .pin_level(ip_in));
    pin_partner #(.W(8)) third_side (.clk(clk), .pin_out(tp_out), .pin_oe_n(tp_oe_n),
        .pin_pullup(tp_pu), .ext_en(tp_en), .ext_val(tp_val), .pin_level(tp_in));

    // Clock at 100 ns period
    initial
    begin
        forever #50 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Strobe held over one rising edge; caller ends a burst with idle
    task automatic wr(input logic [5:0] we, input logic [7:0] d);
        cw = {we, d};
        @(negedge clk);
    endtask
    task automatic idle();
        cw = '0;
        @(negedge clk);
    endtask
    task automatic cleared(input string what);
        check({5'h00, fp_oe_n}, 8'h07, what);
        check({tp_oe_n}, 8'hFF, what);
        check({5'h00, fp_pu} | ip_pu | tp_pu, 8'h00, what);
        check({4'h0, fd_rd} | {4'h0, fc_rd}, 8'h00, what);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_first_port();
        wr(FC, 8'hF3);
        wr(FD, 8'hFB);
        check({4'h0, fc_rd}, 8'h03, "ctrl nibble");
        check({4'h0, fd_rd}, 8'h0B, "data nibble");
        idle();
        check({5'h00, fp_out}, 8'h07, "first out");
        check({5'h00, fp_oe_n}, 8'h04, "first dir");
        check({5'h00, fp_pu}, 8'h04, "first pull");
        check({5'h00, led, led_oe_n, led_hc}, 8'h00, "led");
        wr(FC, 8'h04);
        idle();
        check({5'h00, fp_oe_n}, 8'h07, "all in");
        check({6'h00, led_oe_n, led_hc}, 8'h01, "led hc");
        check({5'h00, fp_pu}, 8'h07, "pull all");
        wr(FD, 8'h05);
        idle();
        check({4'h0, fp_pu, led}, 8'h03, "pull one");
        $display("test_first_port done");
    endtask
    task automatic test_input_port();
        wr(IC | IA, 8'h0F);
        idle();
        check(ip_pu, 8'hF0, "alt pull");
        wr(IC, 8'h00);
        wr(IA, 8'h00);
        wr(IC, 8'h01);
        idle();
        check(ip_pu, 8'hFF, "common pull");
        $display("test_input_port done");
    endtask
    task automatic test_third_port();
        wr(TR, 8'hF0);
        wr(TD, 8'hA5);
        idle();
        check(tp_oe_n, 8'h0F, "third dir");
        check(tp_out, 8'hA5, "third out");
        check(tp_pu, 8'h05, "third pull");
        $display("test_third_port done");
    endtask
    task automatic test_read_path();
        fp_en = 3'b110;
        fp_val = 3'b100;
        ip_en = 8'hFF;
        ip_val = 8'h3C;
        tp_en = 8'h0F;
        tp_val = 8'h0A;
        @(negedge clk);
        @(negedge clk);
        check({5'h00, fp_rd}, 8'h05, "first read");
        check(ip_rd, 8'h3C, "input read");
        check(tp_rd, 8'hAA, "third read");
        $display("test_read_path done");
    endtask
    task automatic test_resets();
        ext_reset_n = 1'b0;
        #10;
        cleared("ext reset");
        @(negedge clk);
        ext_reset_n = 1'b1;
        wr(TR, 8'hFF);
        reset = 1'b1;
        wr(FC, 8'h0F);
        reset = 1'b0;
        idle();
        cleared("sync reset");
        $display("test_resets done");
    endtask

    task automatic give_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (4) @(negedge clk);
        cleared("reset values");
        reset = 1'b0;
        test_first_port();
        test_input_port();
        test_third_port();
        test_read_path();
        test_resets();
        give_verdict();
    end
    // Watchdog: tests need well under 100 cycles
    initial
    begin
        #200000;
        failures++;
        give_verdict();
    end
endmodule
